// ---- hcc_top.v ----
// Harmonic engine configuration register with its ready-event sequencer.
// Assumes an APB master on ref_clk; the harmonic datapath sits outside.
// Assumes any config write, even of the same value, may restart the sequence.
`timescale 1ns/1ns
`include "hcc_defs.vh"

// How it works
// - Timing bit 0: first ready event after settle delay, then at update rate
// - Timing bit 1: ready events start at setup, no delay, then at update rate
// - Channel select bits 2:1: phase A, B, C, or neutral current only
// - Settle delay codes give 500, 750, 1000, 1250 ms; resets to 01
// - Update rate bits 7:5 give 125 us up to 1.024 s; resets to 000
// - Update rate code 111 disables the engine; no updates while held
// - Time-base bits 9:8 pick the reference phase voltage; 00 is phase A
// - Time-base 01 is B, 10 and 11 are C; bits 15:10 unused
module hcc_top #(
  parameter [23:0] CYC_RATE0   = `HCC_CYC_RATE0,
  parameter [23:0] CYC_RATE1   = `HCC_CYC_RATE1,
  parameter [23:0] CYC_RATE2   = `HCC_CYC_RATE2,
  parameter [23:0] CYC_RATE3   = `HCC_CYC_RATE3,
  parameter [23:0] CYC_RATE4   = `HCC_CYC_RATE4,
  parameter [23:0] CYC_RATE5   = `HCC_CYC_RATE5,
  parameter [23:0] CYC_RATE6   = `HCC_CYC_RATE6,
  parameter [23:0] CYC_SETTLE0 = `HCC_CYC_SETTLE0,
  parameter [23:0] CYC_SETTLE1 = `HCC_CYC_SETTLE1,
  parameter [23:0] CYC_SETTLE2 = `HCC_CYC_SETTLE2,
  parameter [23:0] CYC_SETTLE3 = `HCC_CYC_SETTLE3
) (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        arst_n,
  // APB slave
  input  wire [15:0] paddr,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Interrupt
  output reg         irq,
  // Harmonic engine controls
  output reg         harmonic_update,
  output reg         engine_enabled,
  output reg  [1:0]  analysis_channel_select,
  output reg         analysis_voltage_en,
  output reg  [1:0]  time_base_phase_select
);

  // ----------------------------------------------------------------
  // Engine states
  // ----------------------------------------------------------------
  localparam [2:0] ST_OFF    = 3'b001;
  localparam [2:0] ST_SETTLE = 3'b010;
  localparam [2:0] ST_RUN    = 3'b100;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  reg  [9:0]  cfg;
  reg         cfg_restart;
  reg  [2:0]  state;
  reg  [2:0]  next_state;
  reg         tmr_start;
  reg         tmr_stop;
  reg  [23:0] tmr_load;
  reg         fire;
  reg  [23:0] rate_cyc;
  reg  [23:0] settle_cyc;
  reg  [31:0] rdata;
  reg         hit;
  reg  [9:0]  next_cfg;
  wire [31:0] lane_mask;
  wire        setup_rd;
  wire        acc;
  wire        wr;
  wire        ready_timing;
  wire [1:0]  chan_sel;
  wire [1:0]  settle_sel;
  wire [2:0]  rate_sel;
  wire [1:0]  tbase_sel;
  wire        rate_off;
  wire        tmr_running;
  wire        tmr_expired;
  wire [31:0] irq_status;
  wire [31:0] irq_mask;
  wire        irq_level;
  wire [31:0] irq_clr;
  wire [31:0] irq_set;
  wire        mask_we;
  wire [31:0] mask_wdata;

  // ----------------------------------------------------------------
  // Field views
  // ----------------------------------------------------------------
  assign ready_timing = cfg[`HCC_READY_TIMING_BIT];
  assign chan_sel     = cfg[`HCC_CHAN_MSB:`HCC_CHAN_LSB];
  assign settle_sel   = cfg[`HCC_SETTLE_MSB:`HCC_SETTLE_LSB];
  assign rate_sel     = cfg[`HCC_RATE_MSB:`HCC_RATE_LSB];
  assign tbase_sel    = cfg[`HCC_TBASE_MSB:`HCC_TBASE_LSB];
  assign rate_off     = (rate_sel == `HCC_RATE_OFF);

  // ----------------------------------------------------------------
  // APB handshake
  // ----------------------------------------------------------------
  // One wait state: pready rises in the second access cycle
  assign setup_rd = psel & penable & ~pready;
  assign acc      = psel & penable & pready;
  assign wr       = acc & pwrite & hit;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_lane
      assign lane_mask[g*8+7:g*8] = {8{pstrb[g]}};
    end
  endgenerate

  // Unmapped offsets answer with pslverr; their writes are dropped
  // Address decode
  always @* begin
    case (paddr)
      `HCC_OFF_CONFIG:     hit = 1'b1;
      `HCC_OFF_IRQ_STATUS: hit = 1'b1;
      `HCC_OFF_IRQ_MASK:   hit = 1'b1;
      `HCC_OFF_ENGINE:     hit = 1'b1;
      default:             hit = 1'b0;
    endcase
  end

  // Read mux; unused bits read zero
  always @* begin
    case (paddr)
      `HCC_OFF_CONFIG:     rdata = {22'h000000, cfg};
      `HCC_OFF_IRQ_STATUS: rdata = irq_status;
      `HCC_OFF_IRQ_MASK:   rdata = irq_mask;
      `HCC_OFF_ENGINE:     rdata = {27'h0000000, tmr_running, ~rate_off, state};
      default:             rdata = 32'h0000_0000;
    endcase
  end

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup_rd;
      pslverr <= setup_rd & ~hit;
      if (setup_rd) begin
        prdata <= pwrite ? 32'h0000_0000 : rdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration register
  // ----------------------------------------------------------------
  // Byte strobes gate each lane; bits 15:10 have no storage
  always @* begin
    next_cfg = cfg;
    if (pstrb[0]) begin
      next_cfg[7:0] = pwdata[7:0];
    end
    if (pstrb[1]) begin
      next_cfg[9:8] = pwdata[9:8];
    end
  end

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg         <= `HCC_CFG_RESET;
      cfg_restart <= 1'b0;
    end else begin
      cfg_restart <= 1'b0;
      if (wr && paddr == `HCC_OFF_CONFIG) begin
        cfg         <= next_cfg;
        cfg_restart <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interval selection
  // ----------------------------------------------------------------
  always @* begin
    case (rate_sel)
      3'h0:    rate_cyc = CYC_RATE0;
      3'h1:    rate_cyc = CYC_RATE1;
      3'h2:    rate_cyc = CYC_RATE2;
      3'h3:    rate_cyc = CYC_RATE3;
      3'h4:    rate_cyc = CYC_RATE4;
      3'h5:    rate_cyc = CYC_RATE5;
      3'h6:    rate_cyc = CYC_RATE6;
      default: rate_cyc = CYC_RATE6;
    endcase
  end

  always @* begin
    case (settle_sel)
      2'h0:    settle_cyc = CYC_SETTLE0;
      2'h1:    settle_cyc = CYC_SETTLE1;
      2'h2:    settle_cyc = CYC_SETTLE2;
      2'h3:    settle_cyc = CYC_SETTLE3;
      default: settle_cyc = CYC_SETTLE1;
    endcase
  end

  // ----------------------------------------------------------------
  // Engine sequencer
  // ----------------------------------------------------------------
  always @* begin
    next_state = state;
    tmr_start  = 1'b0;
    tmr_stop   = 1'b0;
    // Registered expiry and the restart cycle add two cycles, so a
    // period of N cycles loads N - 2 (needs N of at least 2)
    tmr_load   = rate_cyc - 24'd2;
    fire       = 1'b0;
    case (state)
      ST_OFF: begin
        // A write parks the engine here one cycle before it restarts
        if (!cfg_restart && !rate_off) begin
          tmr_start = 1'b1;
          if (ready_timing) begin
            next_state = ST_RUN;
            fire       = 1'b1;
          end else begin
            next_state = ST_SETTLE;
            tmr_load   = settle_cyc - 24'd1;
          end
        end
      end
      ST_SETTLE: begin
        // Restart or disable both stop the timer and park the engine
        if (cfg_restart || rate_off) begin
          next_state = ST_OFF;
          tmr_stop   = 1'b1;
        end else if (tmr_expired) begin
          next_state = ST_RUN;
          tmr_start  = 1'b1;
          fire       = 1'b1;
        end
      end
      ST_RUN: begin
        if (cfg_restart || rate_off) begin
          next_state = ST_OFF;
          tmr_stop   = 1'b1;
        end else if (tmr_expired) begin
          tmr_start = 1'b1;
          fire      = 1'b1;
        end
      end
      default: begin
        next_state = ST_OFF;
        tmr_stop   = 1'b1;
      end
    endcase
  end

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state           <= ST_OFF;
      harmonic_update <= 1'b0;
    end else begin
      state           <= next_state;
      harmonic_update <= fire;
    end
  end

  // ----------------------------------------------------------------
  // Interval timer
  // ----------------------------------------------------------------
  hcc_timer #(
    .W (24)
  ) hcc_timer_inst (
    .ref_clk  (ref_clk),
    .arst_n   (arst_n),
    .start    (tmr_start),
    .stop     (tmr_stop),
    .load_val (tmr_load),
    .running  (tmr_running),
    .expired  (tmr_expired)
  );

  // ----------------------------------------------------------------
  // Datapath steering
  // ----------------------------------------------------------------
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      engine_enabled          <= 1'b0;
      analysis_channel_select <= 2'h0;
      analysis_voltage_en     <= 1'b1;
      time_base_phase_select  <= 2'h0;
    end else begin
      engine_enabled          <= ~rate_off;
      analysis_channel_select <= chan_sel;
      analysis_voltage_en     <= (chan_sel != `HCC_CHAN_NEUTRAL);
      // Reserved time-base code folds onto phase C
      if (tbase_sel == `HCC_TBASE_RSVD) begin
        time_base_phase_select <= `HCC_TBASE_PHASE_C;
      end else begin
        time_base_phase_select <= tbase_sel;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  assign irq_set    = {12'h000, fire, 19'h00000};
  assign irq_clr    = (wr && paddr == `HCC_OFF_IRQ_STATUS) ? (pwdata & lane_mask)
                                                         : 32'h0000_0000;
  assign mask_we    = wr && (paddr == `HCC_OFF_IRQ_MASK);
  assign mask_wdata = (irq_mask & ~lane_mask) | (pwdata & lane_mask);

  hcc_irq hcc_irq_inst (
    .ref_clk    (ref_clk),
    .arst_n     (arst_n),
    .set_ev     (irq_set),
    .clr        (irq_clr),
    .mask_we    (mask_we),
    .mask_wdata (mask_wdata),
    .status     (irq_status),
    .mask       (irq_mask),
    .irq        (irq_level)
  );

  // ----------------------------------------------------------------
  // Interrupt output
  // ----------------------------------------------------------------
  // Output stage keeps irq one cycle behind the status bit
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_level;
    end
  end

endmodule // hcc_top

// ---- hcc_defs.vh ----
// Constants for the harmonic engine configuration block.
// Assumes a 10 MHz reference clock and a 16-bit APB byte address.
`ifndef HCC_DEFS_VH
`define HCC_DEFS_VH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define HCC_OFF_CONFIG      16'he900
`define HCC_OFF_IRQ_STATUS  16'he904
`define HCC_OFF_IRQ_MASK    16'he908
`define HCC_OFF_ENGINE      16'he90c

// ----------------------------------------------------------------
// Configuration fields
// ----------------------------------------------------------------
`define HCC_READY_TIMING_BIT 0
`define HCC_CHAN_LSB         1
`define HCC_CHAN_MSB         2
`define HCC_SETTLE_LSB       3
`define HCC_SETTLE_MSB       4
`define HCC_RATE_LSB         5
`define HCC_RATE_MSB         7
`define HCC_TBASE_LSB        8
`define HCC_TBASE_MSB        9
`define HCC_CFG_RESET        10'h008
`define HCC_CHAN_NEUTRAL     2'h3
`define HCC_TBASE_RSVD       2'h3
`define HCC_TBASE_PHASE_C    2'h2
`define HCC_RATE_OFF         3'h7

// ----------------------------------------------------------------
// Interrupt fields
// ----------------------------------------------------------------
`define HCC_IRQ_READY_BIT    19
`define HCC_IRQ_VALID        32'h0008_0000
`define HCC_IRQ_RESET        32'h0000_0000
`define HCC_MASK_RESET       32'h0000_0000

// ----------------------------------------------------------------
// Times and cycle counts
// ----------------------------------------------------------------
`define HCC_CLK_KHZ          10000
`define HCC_CYC_PER_US       (`HCC_CLK_KHZ / 1000)
`define HCC_T_RATE0_US       125
`define HCC_T_RATE1_US       250
`define HCC_T_RATE2_US       1000
`define HCC_T_RATE3_US       16000
`define HCC_T_RATE4_US       128000
`define HCC_T_RATE5_US       512000
`define HCC_T_RATE6_US       1024000
`define HCC_T_SETTLE0_MS     500
`define HCC_T_SETTLE1_MS     750
`define HCC_T_SETTLE2_MS     1000
`define HCC_T_SETTLE3_MS     1250
`define HCC_CYC_RATE0        (`HCC_T_RATE0_US * `HCC_CYC_PER_US)
`define HCC_CYC_RATE1        (`HCC_T_RATE1_US * `HCC_CYC_PER_US)
`define HCC_CYC_RATE2        (`HCC_T_RATE2_US * `HCC_CYC_PER_US)
`define HCC_CYC_RATE3        (`HCC_T_RATE3_US * `HCC_CYC_PER_US)
`define HCC_CYC_RATE4        (`HCC_T_RATE4_US * `HCC_CYC_PER_US)
`define HCC_CYC_RATE5        (`HCC_T_RATE5_US * `HCC_CYC_PER_US)
`define HCC_CYC_RATE6        (`HCC_T_RATE6_US * `HCC_CYC_PER_US)
`define HCC_CYC_SETTLE0      (`HCC_T_SETTLE0_MS * 1000 * `HCC_CYC_PER_US)
`define HCC_CYC_SETTLE1      (`HCC_T_SETTLE1_MS * 1000 * `HCC_CYC_PER_US)
`define HCC_CYC_SETTLE2      (`HCC_T_SETTLE2_MS * 1000 * `HCC_CYC_PER_US)
`define HCC_CYC_SETTLE3      (`HCC_T_SETTLE3_MS * 1000 * `HCC_CYC_PER_US)

`endif

// ---- hcc_timer.v ----
// One-shot down counter for the harmonic engine.
// Assumes start and stop are single-cycle pulses from the same clock.
`timescale 1ns/1ns

module hcc_timer #(
  parameter W = 24
) (
  // Clock and reset
  input  wire         ref_clk,
  input  wire         arst_n,
  // Control
  input  wire         start,
  input  wire         stop,
  input  wire [W-1:0] load_val,
  // Status
  output reg          running,
  output reg          expired
);

  reg [W-1:0] count;

  // ----------------------------------------------------------------
  // Expires load_val + 1 cycles after start
  // ----------------------------------------------------------------
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      count   <= {W{1'b0}};
      running <= 1'b0;
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (stop) begin
        running <= 1'b0;
      end else if (start) begin
        count   <= load_val;
        running <= 1'b1;
      end else if (running) begin
        if (count == {W{1'b0}}) begin
          expired <= 1'b1;
          running <= 1'b0;
        end else begin
          count <= count - {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule // hcc_timer

// ---- hcc_irq.v ----
// Sticky interrupt status with mask and one level output.
// Assumes set, clear and mask write come from the same clock.
`timescale 1ns/1ns
`include "hcc_defs.vh"

module hcc_irq (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        arst_n,
  // Events and software access
  input  wire [31:0] set_ev,
  input  wire [31:0] clr,
  input  wire        mask_we,
  input  wire [31:0] mask_wdata,
  // State
  output reg  [31:0] status,
  output reg  [31:0] mask,
  output reg         irq
);

  wire [31:0] next_status;
  wire [31:0] next_mask;

  // Set wins over a clear in the same cycle
  assign next_status = ((status & ~clr) | set_ev) & `HCC_IRQ_VALID;
  assign next_mask   = mask_we ? (mask_wdata & `HCC_IRQ_VALID) : mask;

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      status <= `HCC_IRQ_RESET;
      mask   <= `HCC_MASK_RESET;
      irq    <= 1'b0;
    end else begin
      status <= next_status;
      mask   <= next_mask;
      irq    <= |(next_status & next_mask);
    end
  end

endmodule // hcc_irq

// ---- hcc_top_assertions.sv ----
// Concurrent checks on the harmonic configuration block ports.
// Assumes hcc_top on one clock, ref_clk, with the async reset arst_n.
`timescale 1ns/1ns
`include "hcc_defs.vh"

module hcc_top_assertions #(
  parameter [23:0] CYC_SETTLE0 = 24'd30
) (
  // Clock and reset
  input wire        ref_clk,
  input wire        arst_n,
  // APB
  input wire [15:0] paddr,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  // Engine
  input wire        harmonic_update,
  input wire        engine_enabled,
  input wire [1:0]  analysis_channel_select,
  input wire        analysis_voltage_en,
  input wire [1:0]  time_base_phase_select
);
  // ----------------------------------------------------------------
  // Cycles since the last configuration write
  // ----------------------------------------------------------------
  wire        wr_cfg = psel && penable && pready && pwrite && (paddr == `HCC_OFF_CONFIG);
  reg  [23:0] since_wr;
  reg         t1;

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      since_wr <= 24'h0;
      t1       <= 1'b0;
    end else if (wr_cfg) begin
      since_wr <= 24'h0;
      t1       <= pwdata[0];
    end else if (since_wr != 24'hffffff) begin
      since_wr <= since_wr + 24'h1;
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  property p_volt_en;
    $stable(analysis_channel_select) |-> analysis_voltage_en == (analysis_channel_select != 2'h3);
  endproperty
  a_volt_en: assert property (p_volt_en)
    else $error("voltage path does not follow channel select");
  property p_tbase;
    time_base_phase_select != `HCC_TBASE_RSVD;
  endproperty
  a_tbase: assert property (p_tbase)
    else $error("reserved time base code reached the engine");
  property p_off_quiet;
    !engine_enabled [*2] |-> !harmonic_update;
  endproperty
  a_off_quiet: assert property (p_off_quiet)
    else $error("update while engine disabled");
  property p_spacing;
    harmonic_update |=> !harmonic_update [*7];
  endproperty
  a_spacing: assert property (p_spacing)
    else $error("updates closer than the shortest period");
  property p_settle_gap;
    harmonic_update && !$past(wr_cfg) |-> t1 || (since_wr >= CYC_SETTLE0);
  endproperty
  a_settle_gap: assert property (p_settle_gap)
    else $error("update before the settle delay");
  property p_fast_start;
    wr_cfg && pwdata[0] && (pwdata[7:5] != `HCC_RATE_OFF) |-> ##[1:8] harmonic_update;
  endproperty
  a_fast_start: assert property (p_fast_start)
    else $error("no prompt update with ready timing set");
  property p_off_write;
    wr_cfg && (pwdata[7:5] == `HCC_RATE_OFF) |-> ##[1:3] !engine_enabled;
  endproperty
  a_off_write: assert property (p_off_write)
    else $error("engine still enabled after disable code");
  property p_pready_one;
    pready |=> !pready;
  endproperty
  a_pready_one: assert property (p_pready_one)
    else $error("pready longer than one cycle");
  property p_err_zero;
    pslverr |-> pready && (prdata == 32'h0);
  endproperty
  a_err_zero: assert property (p_err_zero)
    else $error("error response without pready or with data");

  c_fast: cover property (wr_cfg && pwdata[0]);
  c_settled: cover property (harmonic_update && !t1);
  c_err: cover property (pslverr);
endmodule // hcc_top_assertions

bind hcc_top hcc_top_assertions #(.CYC_SETTLE0(CYC_SETTLE0)) hcc_top_assertions_inst (
  .ref_clk(ref_clk), .arst_n(arst_n), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .harmonic_update(harmonic_update), .engine_enabled(engine_enabled),
  .analysis_channel_select(analysis_channel_select),
  .analysis_voltage_en(analysis_voltage_en), .time_base_phase_select(time_base_phase_select));

// ---- test_harmonic_config_control.sv ----
// Self-checking bench for the harmonic configuration block.
// Assumes hcc_top with short rate and settle counts set below.
`timescale 1ns/1ns
`include "hcc_defs.vh"

module test_harmonic_config_control;
  reg         ref_clk;
  reg         arst_n;
  reg  [15:0] paddr;
  reg         psel;
  reg         penable;
  reg         pwrite;
  reg  [31:0] pwdata;
  reg  [3:0]  pstrb;
  wire [31:0] prdata;
  wire        pready, pslverr, irq, harmonic_update, engine_enabled, analysis_voltage_en;
  wire [1:0]  analysis_channel_select;
  wire [1:0]  time_base_phase_select;
  reg  [31:0] rd;
  reg         er;
  integer     n_fail, checked, cyc, n, i;

  // ----------------------------------------------------------------
  // Design, rates 8+2*code cycles, settles 30+10*code cycles
  // ----------------------------------------------------------------
  localparam [23:0] RT0 = 24'd8, RT1 = 24'd10, RT2 = 24'd12, RT3 = 24'd14;
  localparam [23:0] RT4 = 24'd16, RT5 = 24'd18, RT6 = 24'd20;
  localparam [23:0] ST0 = 24'd30, ST1 = 24'd40, ST2 = 24'd50, ST3 = 24'd60;

  hcc_top #(
    .CYC_RATE0(RT0), .CYC_RATE1(RT1), .CYC_RATE2(RT2), .CYC_RATE3(RT3),
    .CYC_RATE4(RT4), .CYC_RATE5(RT5), .CYC_RATE6(RT6),
    .CYC_SETTLE0(ST0), .CYC_SETTLE1(ST1), .CYC_SETTLE2(ST2), .CYC_SETTLE3(ST3)
  ) hcc_top_inst (
    .ref_clk(ref_clk), .arst_n(arst_n), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .harmonic_update(harmonic_update),
    .engine_enabled(engine_enabled), .analysis_channel_select(analysis_channel_select),
    .analysis_voltage_en(analysis_voltage_en), .time_base_phase_select(time_base_phase_select));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task close_out;
    begin
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask

  task check(input [31:0] seen, input [31:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
    end
  endtask

  task apb(input [15:0] a, input w, input [31:0] d);
    begin
      psel    <= 1'b1;
      paddr   <= a;
      pwrite  <= w;
      pwdata  <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
        @(posedge ref_clk);
      end while (pready !== 1'b1);
      check(pready, 1'b1);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
    end
  endtask

  // Cycles until the next update pulse
  task pulse;
    begin
      n = 0;
      do begin
        @(posedge ref_clk);
        n = n + 1;
      end while (harmonic_update !== 1'b1 && n < 4000);
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_reset;
    begin
      apb(`HCC_OFF_CONFIG, 1'b0, 32'h0);
      check(rd, 32'h0000_0008);
      check(time_base_phase_select, 2'h0);
      check(engine_enabled, 1'b1);
      apb(`HCC_OFF_IRQ_MASK, 1'b0, 32'h0);
      check(rd, 32'h0);
    end
  endtask

  task t_fields;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        apb(`HCC_OFF_CONFIG, 1'b1, 32'h0000_fc08 | (i << 8) | (i << 1));
        repeat (2) @(posedge ref_clk);
        check(analysis_channel_select, i);
        check(analysis_voltage_en, i != 3);
        check(time_base_phase_select, (i == 3) ? 2 : i);
        apb(`HCC_OFF_CONFIG, 1'b0, 32'h0);
        check(rd, 32'h0000_0008 | (i << 8) | (i << 1));
      end
      // Lane 1 only: time base changes, low byte keeps 0x0e
      pstrb <= 4'h2;
      apb(`HCC_OFF_CONFIG, 1'b1, 32'h0000_0100);
      pstrb <= 4'hf;
      repeat (2) @(posedge ref_clk);
      check(time_base_phase_select, 2'h1);
      apb(`HCC_OFF_CONFIG, 1'b0, 32'h0);
      check(rd, 32'h0000_010e);
    end
  endtask

  task t_rates;
    begin
      for (i = 0; i < 7; i = i + 1) begin
        repeat (8) @(posedge ref_clk);
        apb(`HCC_OFF_CONFIG, 1'b1, (i << 5) | 1);
        pulse;
        check(n <= 6, 1'b1);
        pulse;
        check(n, 8 + 2 * i);
      end
    end
  endtask

  task t_settle;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        apb(`HCC_OFF_CONFIG, 1'b1, i << 3);
        pulse;
        check(n >= 30 + 10 * i && n <= 38 + 10 * i, 1'b1);
        pulse;
        check(n, 8);
      end
    end
  endtask

  task t_off;
    begin
      apb(`HCC_OFF_CONFIG, 1'b1, 32'h0000_00e0);
      repeat (2) @(posedge ref_clk);
      check(engine_enabled, 1'b0);
      n = 0;
      repeat (200) begin
        @(posedge ref_clk);
        if (harmonic_update === 1'b1)
          n = n + 1;
      end
      check(n, 0);
      apb(`HCC_OFF_ENGINE, 1'b0, 32'h0);
      check(rd[3:0], 4'h1);
    end
  endtask

  task t_irq;
    begin
      apb(`HCC_OFF_IRQ_MASK, 1'b1, `HCC_IRQ_VALID);
      apb(`HCC_OFF_CONFIG, 1'b1, 32'h1);
      pulse;
      repeat (2) @(posedge ref_clk);
      check(irq, 1'b1);
      apb(`HCC_OFF_CONFIG, 1'b1, 32'h0000_00e0);
      apb(`HCC_OFF_IRQ_STATUS, 1'b0, 32'h0);
      check(rd[19], 1'b1);
      apb(`HCC_OFF_IRQ_STATUS, 1'b1, `HCC_IRQ_VALID);
      repeat (2) @(posedge ref_clk);
      check(irq, 1'b0);
      apb(`HCC_OFF_IRQ_MASK, 1'b1, 32'h0);
      apb(`HCC_OFF_CONFIG, 1'b1, 32'h1);
      pulse;
      repeat (2) @(posedge ref_clk);
      check(irq, 1'b0);
      apb(16'he910, 1'b1, 32'hffff_ffff);
      check(er, 1'b1);
      check(rd, 32'h0);
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence and timeout
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      close_out;
    end
  end

  initial begin
    arst_n  = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 16'h0;
    pwdata  = 32'h0;
    pstrb   = 4'hf;
    n_fail  = 0;
    checked = 0;
    cyc     = 0;
    repeat (12) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(posedge ref_clk);
    t_reset;
    t_fields;
    t_rates;
    t_settle;
    t_off;
    t_irq;
    close_out;
  end
endmodule // test_harmonic_config_control
